// ===== uart_alt_defines.svh
`ifndef UART_ALT_DEFINES_SVH
`define UART_ALT_DEFINES_SVH

// register byte offsets
`define OFS_BUFFER 8'h00
`define OFS_IRQ_ENABLE 8'h04
`define OFS_FIFO_CTRL 8'h08
`define OFS_LINE_CTRL 8'h0C
`define OFS_MODEM_CTRL 8'h10
`define OFS_MODEM_STAT 8'h14
`define OFS_FIFO_STAT 8'h18
`define OFS_IRQ_STAT 8'h1C
`define OFS_TIME_OUT 8'h20
`define OFS_BAUD 8'h24
`define OFS_IR_CTRL 8'h28
`define OFS_ALT_CTRL 8'h2C
`define OFS_FUNC_SEL 8'h30

// reset values
`define RST_IRQ_ENABLE 32'h0000_0000
`define RST_FIFO_CTRL 32'h0000_0000
`define RST_LINE_CTRL 32'h0000_0000
`define RST_MODEM_CTRL 32'h0000_0200
`define RST_TIME_OUT 32'h0000_0000
`define RST_BAUD 32'h0F00_0000
`define RST_IR_CTRL 32'h0000_0040
`define RST_ALT_CTRL 32'h0000_0000
`define RST_FUNC_SEL 32'h0000_0000

// field positions
`define FUNC_LO 0
`define FUNC_HI 1
`define FUNC_INFRARED 2'h2
`define FUNC_MULTIDROP 2'h3
`define BAUD_DIV_LO 0
`define BAUD_DIV_HI 15
`define BAUD_DIVX_EN 29
`define LINE_PARITY_EN 3
`define LINE_EVEN_EN 4
`define LINE_STICK_EN 5
`define MODEM_RTS 1
`define MODEM_RTS_LEVEL 9
`define FIFO_MD_RECEIVE_DISABLE 8
`define TIME_DLY_LO 8
`define TIME_DLY_HI 15
`define IR_TX_SELECT 1
`define IR_TX_INV 5
`define IR_RX_INV 6
`define ALT_NORMAL_MD 8
`define ALT_AUTO_ADDR 9
`define ALT_AUTO_DIR 10
`define ALT_RECEIVE_DISABLE 15
`define ALT_MATCH_LO 24
`define ALT_MATCH_HI 31
`define IEN_RX_AVAIL 0
`define IEN_ADDR 2
`define STAT_RX_AVAIL 0
`define STAT_TX_EMPTY 1
`define STAT_ADDR 2
`define FSTAT_RX_EMPTY 14
`define FSTAT_TX_EMPTY 22
`define FSTAT_TX_IDLE 28

// timing
`define SUBTICKS_PER_BIT 16
`define IR_PULSE_SUBTICKS 3
`define RX_MID_SUBTICK 7

`endif

// ===== uart_alt_pkg.sv
package uart_alt_pkg;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    typedef enum logic [2:0] {T_IDLE, T_LEAD, T_START, T_DATA, T_PARITY, T_STOP, T_HOLD} tx_state_t;
    typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PARITY, R_STOP} rx_state_t;

endpackage : uart_alt_pkg

// ===== uart_alt.sv
// Behaviour
// - infrared only when function select says so
// - bit rate is clock over sixteen times divider
// - encoder pulses on zero bits only
// - pulse lasts three sixteenths of bit
// - receive inversion bit six resets to one
// - decoder finds start on low, gives NRZ
// - infrared path half duplex only
// - multidrop selected, rts drives line enable
// - ninth bit one address, zero data
// - stick parity sets ninth bit value
// - three multidrop modes in alternate control
// - turnaround delay field sets enable release
// - receive-disable drops characters until address
// - receive-disable clear stores every character except in auto address mode, or in normal mode after an address with ALT_RECEIVE_DISABLE set
// - address detection in normal multidrop mode raises interrupt
// - auto address stores matching address only
// - store until non-matching address arrives
// - rts high enables driver, low tristates
// - rts level invertible in modem control
// - offset zero reads receive, writes transmit
// - frames carry start, eight data, stop
`timescale 1ns/100ps
`include "uart_alt_defines.svh"

module uart_alt
    import uart_alt_pkg::*;
#(
    parameter int DIV_W = 16,
    parameter int DLY_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire axi_req_t axi_req,
    output axi_rsp_t axi_rsp,
    input wire logic rx_in,
    output logic tx_out,
    output logic rts_out,
    output logic irq
);

    generate
        if (DIV_W < 1 || DIV_W > 16 || DLY_W != 8) begin : g_bad_param
            $error("uart_alt: DIV_W must be 1..16 and DLY_W 8");
        end
    endgenerate

    logic [31:0] irq_enable, fifo_ctrl, line_ctrl, modem_ctrl, time_out, baud, ir_ctrl, alt_ctrl, func_sel;

    // bus slave: address and data latched independently
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = axi_req.awvalid && axi_rsp.awready;
    wire w_take = axi_req.wvalid && axi_rsp.wready;
    wire do_write = aw_held && w_held && !axi_rsp.bvalid;
    wire ar_take = axi_req.arvalid && axi_rsp.arready;
    wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire [31:0] wmerge_base = w_data & wmask;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m, input logic [31:0] d);
        merge = (old & ~m) | d;
    endfunction

    wire wr_buf = do_write && aw_addr == `OFS_BUFFER;
    wire wr_ien = do_write && aw_addr == `OFS_IRQ_ENABLE;
    wire wr_fifo = do_write && aw_addr == `OFS_FIFO_CTRL;
    wire wr_line = do_write && aw_addr == `OFS_LINE_CTRL;
    wire wr_modem = do_write && aw_addr == `OFS_MODEM_CTRL;
    wire wr_stat = do_write && aw_addr == `OFS_IRQ_STAT;
    wire wr_tout = do_write && aw_addr == `OFS_TIME_OUT;
    wire wr_baud = do_write && aw_addr == `OFS_BAUD;
    wire wr_ir = do_write && aw_addr == `OFS_IR_CTRL;
    wire wr_alt = do_write && aw_addr == `OFS_ALT_CTRL;
    wire wr_func = do_write && aw_addr == `OFS_FUNC_SEL;
    wire wr_known = wr_buf | wr_ien | wr_fifo | wr_line | wr_modem | wr_stat | wr_tout | wr_baud | wr_ir | wr_alt
        | wr_func | (do_write && aw_addr == `OFS_MODEM_STAT) | (do_write && aw_addr == `OFS_FIFO_STAT);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= {axi_req.awaddr[7:2], 2'b00};
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= axi_req.wdata;
                w_strb <= axi_req.wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_enable <= `RST_IRQ_ENABLE;
            fifo_ctrl <= `RST_FIFO_CTRL;
            line_ctrl <= `RST_LINE_CTRL;
            modem_ctrl <= `RST_MODEM_CTRL;
            time_out <= `RST_TIME_OUT;
            baud <= `RST_BAUD;
            ir_ctrl <= `RST_IR_CTRL;
            alt_ctrl <= `RST_ALT_CTRL;
            func_sel <= `RST_FUNC_SEL;
        end else begin
            if (wr_ien) irq_enable <= merge(irq_enable, wmask, wmerge_base);
            if (wr_fifo) fifo_ctrl <= merge(fifo_ctrl, wmask, wmerge_base);
            if (wr_line) line_ctrl <= merge(line_ctrl, wmask, wmerge_base);
            if (wr_modem) modem_ctrl <= merge(modem_ctrl, wmask, wmerge_base);
            if (wr_tout) time_out <= merge(time_out, wmask, wmerge_base);
            if (wr_baud) baud <= merge(baud, wmask, wmerge_base);
            if (wr_ir) ir_ctrl <= merge(ir_ctrl, wmask, wmerge_base);
            if (wr_alt) alt_ctrl <= merge(alt_ctrl, wmask, wmerge_base);
            if (wr_func) func_sel <= merge(func_sel, wmask, wmerge_base);
        end
    end

    // mode decode
    // infrared select
    wire ir_mode = func_sel[`FUNC_HI:`FUNC_LO] == `FUNC_INFRARED;
    wire md_mode = func_sel[`FUNC_HI:`FUNC_LO] == `FUNC_MULTIDROP;
    wire md_normal = md_mode && alt_ctrl[`ALT_NORMAL_MD];
    wire md_auto_addr = md_mode && alt_ctrl[`ALT_AUTO_ADDR];
    wire md_auto_dir = md_mode && alt_ctrl[`ALT_AUTO_DIR];
    wire ir_tx_sel = ir_ctrl[`IR_TX_SELECT];
    wire parity_en = line_ctrl[`LINE_PARITY_EN];
    wire [7:0] dly = time_out[`TIME_DLY_HI:`TIME_DLY_LO];
    wire [7:0] match_val = alt_ctrl[`ALT_MATCH_HI:`ALT_MATCH_LO];

    // sub-tick every divider clocks, sixteen per bit
    logic [DIV_W-1:0] div_cnt;
    wire [DIV_W-1:0] div_val = baud[DIV_W-1:0];
    wire [DIV_W-1:0] div_last = (div_val == '0) ? '0 : div_val - 1'b1;
    wire sub_tick = div_cnt >= div_last;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) div_cnt <= '0;
        else div_cnt <= sub_tick ? '0 : div_cnt + 1'b1;
    end

    // transmit side
    tx_state_t tx_state, next_tx_state;
    logic [7:0] hold_data, tx_shift;
    logic hold_full, tx_ninth, tx_bit;
    logic [3:0] tx_sub;
    logic [2:0] tx_idx;
    logic [7:0] dly_cnt;
    wire tx_bit_end = sub_tick && tx_sub == 4'(`SUBTICKS_PER_BIT - 1);
    wire hold_load = wr_buf && wmask[7:0] == 8'hFF && !hold_full;
    wire tx_take = (tx_state == T_IDLE || tx_state == T_HOLD) && hold_full && !(ir_mode && !ir_tx_sel);

    // stick parity gives fixed ninth bit
    wire ninth_calc = line_ctrl[`LINE_STICK_EN] ? !line_ctrl[`LINE_EVEN_EN]
        : (line_ctrl[`LINE_EVEN_EN] ? ^hold_data : ~^hold_data);

    always_comb begin
        next_tx_state = tx_state;
        case (tx_state)
            T_IDLE, T_HOLD: begin
                if (tx_take) begin
                    // enable raised a bit ahead of start
                    next_tx_state = (md_auto_dir && tx_state == T_IDLE) ? T_LEAD : T_START;
                end else if (tx_state == T_HOLD && tx_bit_end && dly_cnt == 8'h00) begin
                    next_tx_state = T_IDLE;
                end
            end
            T_LEAD: if (tx_bit_end) next_tx_state = T_START;
            T_START: if (tx_bit_end) next_tx_state = T_DATA;
            T_DATA: if (tx_bit_end && tx_idx == 3'h7) next_tx_state = parity_en ? T_PARITY : T_STOP;
            T_PARITY: if (tx_bit_end) next_tx_state = T_STOP;
            T_STOP: if (tx_bit_end) next_tx_state = (md_auto_dir && dly != 8'h00) ? T_HOLD : T_IDLE;
            default: next_tx_state = T_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state <= T_IDLE;
            hold_full <= 1'b0;
            hold_data <= 8'h00;
            tx_shift <= 8'h00;
            tx_ninth <= 1'b0;
            tx_sub <= 4'h0;
            tx_idx <= 3'h0;
            dly_cnt <= 8'h00;
        end else begin
            tx_state <= next_tx_state;
            if (hold_load) begin
                hold_full <= 1'b1;
                hold_data <= wmerge_base[7:0];
            end else if (tx_take) begin
                hold_full <= 1'b0;
            end
            if (tx_take) begin
                tx_shift <= hold_data;
                tx_ninth <= ninth_calc;
                tx_idx <= 3'h0;
                tx_sub <= 4'h0;
            end else if (sub_tick) begin
                tx_sub <= tx_sub + 4'h1;
            end
            if (tx_state == T_DATA && tx_bit_end) begin
                tx_shift <= {1'b0, tx_shift[7:1]};
                tx_idx <= tx_idx + 3'h1;
            end
            if (tx_state == T_STOP && tx_bit_end) dly_cnt <= dly - 8'h01;
            else if (tx_state == T_HOLD && tx_bit_end && dly_cnt != 8'h00) dly_cnt <= dly_cnt - 8'h01;
        end
    end

    always_comb begin
        case (tx_state)
            T_START: tx_bit = 1'b0;
            T_DATA: tx_bit = tx_shift[0];
            T_PARITY: tx_bit = tx_ninth;
            default: tx_bit = 1'b1;
        endcase
    end

    wire ir_pulse = !tx_bit && tx_sub < 4'(`IR_PULSE_SUBTICKS);
    wire ir_line = (ir_tx_sel && ir_pulse) ^ ir_ctrl[`IR_TX_INV];
    wire next_tx_out = ir_mode ? ir_line : tx_bit;

    // enable spans lead, frame and delay
    wire drv_active = tx_state != T_IDLE;
    wire rts_level = md_auto_dir ? drv_active : modem_ctrl[`MODEM_RTS];
    wire next_rts_out = modem_ctrl[`MODEM_RTS_LEVEL] ? rts_level : !rts_level;

    // infrared decoder: a pulse stretches to a whole low bit
    logic [4:0] ir_stretch;
    wire ir_raw = rx_in ^ ir_ctrl[`IR_RX_INV];
    wire ir_nrz = ir_stretch == 5'h00;
    wire rx_line = ir_mode ? (ir_tx_sel ? 1'b1 : ir_nrz) : rx_in;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) ir_stretch <= 5'h00;
        else if (ir_raw && !ir_tx_sel) ir_stretch <= 5'(`SUBTICKS_PER_BIT);
        else if (sub_tick && ir_stretch != 5'h00) ir_stretch <= ir_stretch - 5'h01;
    end

    // receive side
    rx_state_t rx_state, next_rx_state;
    logic [3:0] rx_sub;
    logic [2:0] rx_idx;
    logic [7:0] rx_shift, rx_data;
    logic rx_ninth, rx_full, md_accept, addr_flag;
    wire rx_sample = sub_tick && rx_sub == 4'(`SUBTICKS_PER_BIT - 1);
    wire rx_mid = sub_tick && rx_sub == 4'(`RX_MID_SUBTICK);
    wire rx_done = rx_state == R_STOP && rx_sample;

    always_comb begin
        next_rx_state = rx_state;
        case (rx_state)
            R_IDLE: if (!rx_line) next_rx_state = R_START;
            R_START: begin
                if (rx_mid) next_rx_state = rx_line ? R_IDLE : R_DATA;
            end
            R_DATA: if (rx_sample && rx_idx == 3'h7) next_rx_state = parity_en ? R_PARITY : R_STOP;
            R_PARITY: if (rx_sample) next_rx_state = R_STOP;
            R_STOP: if (rx_sample) next_rx_state = R_IDLE;
            default: next_rx_state = R_IDLE;
        endcase
    end

    // multidrop receive filter
    wire is_addr = md_mode && parity_en && rx_ninth;
    wire addr_match = rx_shift == match_val;
    logic store_char, next_accept;
    always_comb begin
        store_char = 1'b1;
        next_accept = md_accept;
        if (md_auto_addr) begin
            store_char = is_addr ? addr_match : md_accept;
            next_accept = is_addr ? addr_match : md_accept;
        end else if (md_normal) begin
            store_char = is_addr || md_accept;
            next_accept = is_addr ? !alt_ctrl[`ALT_RECEIVE_DISABLE] : md_accept;
        end
    end

    wire rd_buf = ar_take && {axi_req.araddr[7:2], 2'b00} == `OFS_BUFFER;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= R_IDLE;
            rx_sub <= 4'h0;
            rx_idx <= 3'h0;
            rx_shift <= 8'h00;
            rx_ninth <= 1'b0;
            rx_data <= 8'h00;
            rx_full <= 1'b0;
            md_accept <= 1'b1;
            addr_flag <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            if (rx_state == R_IDLE) rx_sub <= 4'h0;
            else if (rx_mid && rx_state == R_START) rx_sub <= 4'h0;
            else if (sub_tick) rx_sub <= rx_sub + 4'h1;
            if (rx_state == R_START) rx_idx <= 3'h0;
            if (rx_state == R_DATA && rx_sample) begin
                rx_shift <= {rx_line, rx_shift[7:1]};
                rx_idx <= rx_idx + 3'h1;
            end
            if (rx_state == R_START) rx_ninth <= 1'b0;
            else if (rx_state == R_PARITY && rx_sample) rx_ninth <= rx_line;
            // reload the filter on every fifo control write, from its receive-disable bit
            if (wr_fifo) md_accept <= !(wmask[`FIFO_MD_RECEIVE_DISABLE] ? w_data[`FIFO_MD_RECEIVE_DISABLE] : fifo_ctrl[`FIFO_MD_RECEIVE_DISABLE]);
            else if (rx_done) md_accept <= next_accept;
            if (rx_done && store_char) begin
                rx_data <= rx_shift;
                rx_full <= 1'b1;
            end else if (rd_buf) begin
                rx_full <= 1'b0;
            end
            // sticky address flag, set beats clear
            if (rx_done && md_normal && is_addr) addr_flag <= 1'b1;
            else if (wr_stat && wmerge_base[`STAT_ADDR]) addr_flag <= 1'b0;
        end
    end

    // read mux
    wire tx_empty = !hold_full;
    wire tx_idle = !hold_full && tx_state == T_IDLE;
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case ({axi_req.araddr[7:2], 2'b00})
            `OFS_BUFFER: rd_val = {24'h000000, rx_data};
            `OFS_IRQ_ENABLE: rd_val = irq_enable;
            `OFS_FIFO_CTRL: rd_val = fifo_ctrl;
            `OFS_LINE_CTRL: rd_val = line_ctrl;
            `OFS_MODEM_CTRL: rd_val = modem_ctrl;
            `OFS_MODEM_STAT: rd_val = 32'h0000_0000;
            `OFS_FIFO_STAT: rd_val = (32'(!rx_full) << `FSTAT_RX_EMPTY) | (32'(tx_empty) << `FSTAT_TX_EMPTY)
                | (32'(tx_idle) << `FSTAT_TX_IDLE);
            `OFS_IRQ_STAT: rd_val = (32'(rx_full) << `STAT_RX_AVAIL) | (32'(tx_empty) << `STAT_TX_EMPTY)
                | (32'(addr_flag) << `STAT_ADDR);
            `OFS_TIME_OUT: rd_val = time_out;
            `OFS_BAUD: rd_val = baud;
            `OFS_IR_CTRL: rd_val = ir_ctrl;
            `OFS_ALT_CTRL: rd_val = alt_ctrl;
            `OFS_FUNC_SEL: rd_val = func_sel;
            default: begin
                rd_val = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end

    wire next_irq = (irq_enable[`IEN_RX_AVAIL] && rx_full) || (irq_enable[`IEN_ADDR] && addr_flag);

    // outputs all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            axi_rsp <= '0;
            tx_out <= 1'b1;
            rts_out <= 1'b0;
            irq <= 1'b0;
        end else begin
            axi_rsp.awready <= !aw_held && !aw_take;
            axi_rsp.wready <= !w_held && !w_take;
            if (do_write) begin
                axi_rsp.bvalid <= 1'b1;
                axi_rsp.bresp <= wr_known ? 2'b00 : 2'b10;
            end else if (axi_req.bready) begin
                axi_rsp.bvalid <= 1'b0;
            end
            axi_rsp.arready <= !ar_take && !(axi_rsp.rvalid && !axi_req.rready);
            if (ar_take) begin
                axi_rsp.rvalid <= 1'b1;
                axi_rsp.rdata <= rd_val;
                axi_rsp.rresp <= rd_ok ? 2'b00 : 2'b10;
            end else if (axi_req.rready) begin
                axi_rsp.rvalid <= 1'b0;
            end
            tx_out <= next_tx_out;
            rts_out <= next_rts_out;
            irq <= next_irq;
        end
    end

endmodule : uart_alt

// ===== uart_alt_properties.sv
`timescale 1ns/100ps
module uart_alt_properties
    import uart_alt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire axi_req_t axi_req,
    input wire axi_rsp_t axi_rsp,
    input wire logic rx_in,
    input wire logic tx_out,
    input wire logic rts_out,
    input wire logic irq
);
    logic [1:0] func;
    logic auto_dir;
    logic lvl;
    wire wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    wire ir = func == 2'h2;
    wire ar_take = axi_req.arvalid && axi_rsp.arready;
    // mode mirror; only paired address/data takes are seen
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            func <= 2'h0;
            auto_dir <= 1'b0;
            lvl <= 1'b1;
        end else if (wr_take) begin
            if (axi_req.awaddr == 8'h30) func <= axi_req.wdata[1:0];
            if (axi_req.awaddr == 8'h2C) auto_dir <= axi_req.wdata[10];
            if (axi_req.awaddr == 8'h10) lvl <= axi_req.wdata[9];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_read_answer; ar_take |=> axi_rsp.rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_write_answer; wr_take |-> ##2 axi_rsp.bvalid; endproperty
    a_write_answer: assert property (p_write_answer) else $error("write answer late");
    property p_aw_drop; axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready; endproperty
    a_aw_drop: assert property (p_aw_drop) else $error("address ready held");
    property p_r_release; axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid; endproperty
    a_r_release: assert property (p_r_release) else $error("read data not released");
    property p_unmapped; ar_take && axi_req.araddr == 8'h40 |=> axi_rsp.rresp == 2'h2; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_ir_pulse; ir && $rose(tx_out) |-> tx_out [*3] ##1 !tx_out; endproperty
    a_ir_pulse: assert property (p_ir_pulse) else $error("light pulse width wrong");
    property p_nrz_low; !ir && $fell(tx_out) |-> !tx_out [*8]; endproperty
    a_nrz_low: assert property (p_nrz_low) else $error("plain stream altered");
    property p_dir_on; auto_dir && $fell(tx_out) |-> rts_out == lvl && $past(rts_out) == lvl; endproperty
    a_dir_on: assert property (p_dir_on) else $error("driver not enabled ahead of bits");
endmodule : uart_alt_properties

bind uart_alt uart_alt_properties uart_alt_properties_i (.clk(clk), .rst(rst), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .rx_in(rx_in), .tx_out(tx_out), .rts_out(rts_out), .irq(irq));

// ===== uart_alt_peer.sv
`timescale 1ns/100ps
module uart_alt_peer (
    input wire logic clk,
    input wire logic tx_out,
    output logic rx_in
);
    // line idles high between frames
    initial rx_in = 1'b1;
    task automatic put_bit(input logic b, input bit ir);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            // detector low only early in zero bits
            rx_in <= ir ? (b || k >= 3) : b;
        end
    endtask : put_bit
    task automatic send(input logic [7:0] d, input bit nine, input logic b9, input bit ir);
        put_bit(1'b0, ir);
        for (int i = 0; i < 8; i++) put_bit(d[i], ir);
        if (nine) put_bit(b9, ir);
        put_bit(1'b1, ir);
    endtask : send
    // samples mid-bit; bt is clocks per bit
    task automatic grab(input int nb, input int bt, output logic [8:0] v);
        v = 9'h0;
        // skip the tail of a frame still on the line
        while (tx_out !== 1'b1) @(posedge clk);
        while (tx_out !== 1'b0) @(posedge clk);
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i < nb; i++) begin
            repeat (bt) @(posedge clk);
            v[i] = tx_out;
        end
    endtask : grab
endmodule : uart_alt_peer

// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top
    import uart_alt_pkg::*;
;
    logic clk, rst, rx, tx, rts, irq, prev;
    axi_req_t req;
    axi_rsp_t rsp;
    logic [31:0] d;
    logic [1:0] r;
    logic [8:0] v;
    int errors, samples_checked, cycles, n;
    logic [31:0] rtab [13] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h200, 32'h0, 32'h10404000,
        32'h2, 32'h0, 32'h0F000000, 32'h40, 32'h0, 32'h0};
    logic [8:0] aseq [6] = '{9'h111, 9'h044, 9'h15A, 9'h066, 9'h177, 9'h055};
    uart_alt #(.DIV_W(16), .DLY_W(8)) uart_alt_i (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
        .rx_in(rx), .tx_out(tx), .rts_out(rts), .irq(irq));
    uart_alt_peer uart_alt_peer_i (.clk(clk), .tx_out(tx), .rx_in(rx));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic final_report();
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    // hang guard, frames need a few thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            errors++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= dat;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        r = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
    endtask : rd
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        rd(a);
        chk(nm, e, d & m);
    endtask : rchk
    // filtered-out characters leave the buffer empty
    task automatic rx_expect(input logic [7:0] c, input bit n9, b9, ir, acc);
        uart_alt_peer_i.send(c, n9, b9, ir);
        repeat (4) @(posedge clk);
        rchk("rx empty", 8'h18, 32'h4000, acc ? 32'h0 : 32'h4000);
        if (acc) rchk("rx char", 8'h00, 32'hFF, {24'h0, c});
    endtask : rx_expect
    initial begin
        rst = 1'b1;
        req = '0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 1; i < 13; i++) rchk("reset value", 8'(i * 4), 32'hFFFFFFFF, rtab[i]);
        rd(8'h40);
        chk("unmapped resp", 32'h2, 32'(r));
        wr(8'h40, 32'h0);
        chk("unmapped write resp", 32'h2, 32'(r));
        wr(8'h24, 32'h2);
        fork wr(8'h00, 32'hA5); uart_alt_peer_i.grab(8, 32, v); join
        chk("tx slow rate", 32'hA5, 32'(v));
        wr(8'h24, 32'h1);
        rx_expect(8'h3C, 1'b0, 1'b0, 1'b0, 1'b1);
        wr(8'h30, 32'h2);
        wr(8'h28, 32'h42);
        n = 0;
        prev = tx;
        fork wr(8'h00, 32'h0F); repeat (200) begin @(posedge clk); n += 32'(tx && !prev); prev = tx; end join
        chk("light pulses", 32'h5, 32'(n));
        rx_expect(8'h81, 1'b0, 1'b0, 1'b1, 1'b0);
        wr(8'h28, 32'h40);
        rx_expect(8'hC3, 1'b0, 1'b0, 1'b1, 1'b1);
        wr(8'h30, 32'h3);
        for (int i = 0; i < 2; i++) begin
            wr(8'h0C, i ? 32'h28 : 32'h38);
            fork wr(8'h00, 32'h96); uart_alt_peer_i.grab(9, 16, v); join
            chk("ninth bit", {23'h0, i[0], 8'h96}, 32'(v));
        end
        wr(8'h04, 32'h4);
        wr(8'h0C, 32'h08);
        wr(8'h08, 32'h100);
        wr(8'h2C, 32'h100);
        rx_expect(8'h11, 1'b1, 1'b0, 1'b0, 1'b0);
        rx_expect(8'h22, 1'b1, 1'b1, 1'b0, 1'b1);
        chk("address irq", 32'h1, 32'(irq));
        wr(8'h1C, 32'h4);
        repeat (2) @(posedge clk);
        chk("address irq clear", 32'h0, 32'(irq));
        wr(8'h08, 32'h0);
        rx_expect(8'h33, 1'b1, 1'b0, 1'b0, 1'b1);
        wr(8'h2C, 32'h5A000200);
        for (int i = 0; i < 6; i++) rx_expect(aseq[i][7:0], 1'b1, aseq[i][8], 1'b0, i == 2 || i == 3);
        wr(8'h0C, 32'h0);
        wr(8'h2C, 32'h400);
        wr(8'h20, 32'h200);
        chk("driver off", 32'h0, 32'(rts));
        n = 0;
        fork wr(8'h00, 32'h55); repeat (400) begin @(posedge clk); n += 32'(rts); end join
        chk("enable span", 32'h1, 32'(n >= 206 && n <= 210));
        wr(8'h10, 32'h0);
        repeat (2) @(posedge clk);
        chk("inverted idle", 32'h1, 32'(rts));
        final_report();
    end
endmodule : tb_top
